// File: src/tlf_pkg.sv
// Constants and carrier types for the secure transmit and config response framer
package tlf_pkg;

    localparam logic [7:0] TYPE_TX_TLS = 8'h23;
    localparam logic [7:0] TYPE_CFG_CMD = 8'h08;
    localparam logic [7:0] TYPE_CFG_RESP = 8'h88;
    localparam logic [7:0] TYPE_TX_STATUS = 8'h89;
    localparam logic [7:0] FRAME_DELIM = 8'h7e;
    localparam logic [7:0] CSUM_GOOD = 8'hff;

    // Transmit status codes
    localparam logic [7:0] TXST_OK = 8'h00;
    localparam logic [7:0] TXST_NO_CONN = 8'h20;
    localparam logic [7:0] TXST_BAD_FRAME = 8'h2c;
    localparam logic [7:0] TXST_RESOURCE = 8'h32;
    localparam logic [7:0] TXST_TOO_LONG = 8'h74;

    // Config response status codes
    localparam logic [7:0] CFG_OK = 8'h00;
    localparam logic [7:0] CFG_ERROR = 8'h01;
    localparam logic [7:0] CFG_BAD_CMD = 8'h02;
    localparam logic [7:0] CFG_BAD_PARAM = 8'h03;

    // Byte positions inside the frame data
    localparam logic [10:0] IDX_TYPE = 11'h000;
    localparam logic [10:0] IDX_FID = 11'h001;
    localparam logic [10:0] IDX_DADDR_LAST = 11'h005;
    localparam logic [10:0] IDX_DPORT_LAST = 11'h007;
    localparam logic [10:0] IDX_SPORT_LAST = 11'h009;
    localparam logic [10:0] IDX_PROFILE = 11'h00a;
    localparam logic [10:0] IDX_OPTIONS = 11'h00b;
    localparam logic [10:0] IDX_PAYLOAD = 11'h00c;
    localparam logic [10:0] IDX_CMD_HI = 11'h002;
    localparam logic [10:0] IDX_CMD_LO = 11'h003;
    localparam logic [10:0] IDX_PARAM = 11'h004;
    localparam logic [10:0] IDX_MAX = 11'h7ff;

    localparam int OPT_CLOSE_BIT = 1;
    localparam logic [10:0] MAX_PAYLOAD = 11'h5dc;
    // Secure transport always runs over TCP
    localparam logic TLS_IS_UDP = 1'b0;

    localparam logic [7:0] CMD_IDLE_HI = 8'h54;
    localparam logic [7:0] CMD_IDLE_LO = 8'h4d;
    localparam logic [15:0] IDLE_TIMEOUT_RESET = 16'h012c;

    localparam int CLK_HZ = 50000000;
    localparam int IDLE_TICK_MS = 100;
    localparam int IDLE_TICK_CYCLES = CLK_HZ / 1000 * IDLE_TICK_MS;

    localparam int NSOCK = 4;
    localparam logic [15:0] EPHEM_PORT_BASE = 16'hc000;
    localparam int FIFO_DEPTH = 4;
    localparam int RESP_MAX = 7;
    localparam logic [2:0] RESP_LEN_STATUS = 3'h3;
    localparam logic [2:0] RESP_LEN_CFG_SET = 3'h5;
    localparam logic [2:0] RESP_LEN_CFG_GET = 3'h7;

    typedef struct packed {
        logic open;
        logic [15:0] src_port;
        logic [31:0] dst_addr;
        logic [15:0] dst_port;
        logic [7:0] profile;
        logic [15:0] idle;
    } tlf_sock_t;

    typedef struct packed {
        logic drop;
        logic last;
        logic [1:0] sock;
        logic [7:0] profile;
        logic [7:0] data;
    } tlf_net_word_t;

endpackage

// File: src/tlf_fifo.sv
// Small FIFO with a registered output stage
`timescale 1ns/10ps
`default_nettype none
module tlf_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 4
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready,
    output logic [$clog2(DEPTH+1)-1:0] count
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [CW-1:0] next_count;
    logic next_out_valid;
    logic [WIDTH-1:0] next_out_data;
    logic push, pop;

    always_comb begin
        push = in_valid && in_ready;
        pop = (count != '0) && (!out_valid || out_ready);
        next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
        next_count = CW'(count + CW'(push) - CW'(pop));
        next_out_valid = pop || (out_valid && !out_ready);
        next_out_data = pop ? mem[rd_ptr] : out_data;
        in_ready = count != CW'(DEPTH);
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            out_valid <= 1'b0;
            out_data <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            out_valid <= next_out_valid;
            out_data <= next_out_data;
        end
    end

    // Storage holds no control state, so it needs no reset
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule // tlf_fifo
`default_nettype wire

// File: src/tlf_framer.sv
// Secure transmit request parser, socket matcher and config/status response framer
`timescale 1ns/10ps
`default_nettype none
module tlf_framer #(
    parameter int TICK_CYCLES = tlf_pkg::IDLE_TICK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    output logic rx_ready,
    output logic host_valid,
    output logic [7:0] host_data,
    input wire logic host_ready,
    output logic net_valid,
    output tlf_pkg::tlf_net_word_t net_word,
    input wire logic net_ready
);
    typedef enum logic [2:0] {S_IDLE, S_LENH, S_LENL, S_DATA, S_SUM} tlf_ser_t;

    function automatic logic sock_match(input tlf_pkg::tlf_sock_t s, input logic [31:0] a,
                                        input logic [15:0] dp, input logic [15:0] sp);
        sock_match = s.open && s.dst_addr == a && s.dst_port == dp &&
                     (sp == 16'h0000 || s.src_port == sp);
    endfunction

    logic [10:0] idx, paylen;
    logic [7:0] ftype, fid, prof, opts, pend_byte, csum, tx_st, cmd_hi, cmd_lo, par_hi;
    logic [7:0] par_lo;
    logic [31:0] daddr, tick_cnt;
    logic [15:0] dport, sport, idle_tm;
    logic pend_v, sock_ok, too_long;
    logic [1:0] sock_sel;
    tlf_pkg::tlf_sock_t tab [tlf_pkg::NSOCK];
    logic [7:0] rbuf [tlf_pkg::RESP_MAX];
    logic [2:0] rlen;

    logic [10:0] next_idx, next_paylen;
    logic [7:0] next_ftype, next_fid, next_prof, next_opts, next_pend_byte, next_csum;
    logic [7:0] next_tx_st, next_cmd_hi, next_cmd_lo, next_par_hi, next_par_lo;
    logic [31:0] next_daddr, next_tick_cnt;
    logic [15:0] next_dport, next_sport, next_idle_tm;
    logic next_pend_v, next_sock_ok, next_too_long, next_rx_ready;
    logic [1:0] next_sock_sel;
    tlf_pkg::tlf_sock_t next_tab [tlf_pkg::NSOCK];
    logic [7:0] next_rbuf [tlf_pkg::RESP_MAX];
    logic [2:0] next_rlen;

    logic accept, tick, good, found, resp_start, push, fifo_ready;
    logic [7:0] cfg_st;
    logic [2:0] fifo_cnt;
    tlf_pkg::tlf_net_word_t push_word;

    tlf_ser_t ser_state, next_ser_state;
    logic [2:0] ser_idx, next_ser_idx;
    logic [7:0] ser_csum, next_ser_csum, next_host_data;
    logic next_host_valid;

    always_comb begin
        next_idx = idx;
        next_paylen = paylen;
        next_ftype = ftype;
        next_fid = fid;
        next_prof = prof;
        next_opts = opts;
        next_pend_byte = pend_byte;
        next_csum = csum;
        next_tx_st = tx_st;
        next_cmd_hi = cmd_hi;
        next_cmd_lo = cmd_lo;
        next_par_hi = par_hi;
        next_par_lo = par_lo;
        next_daddr = daddr;
        next_dport = dport;
        next_sport = sport;
        next_idle_tm = idle_tm;
        next_pend_v = pend_v;
        next_sock_ok = sock_ok;
        next_too_long = too_long;
        next_sock_sel = sock_sel;
        next_tab = tab;
        next_rbuf = rbuf;
        next_rlen = rlen;
        push = 1'b0;
        push_word = '0;
        resp_start = 1'b0;
        found = 1'b0;
        cfg_st = tlf_pkg::CFG_OK;
        good = 1'b0;
        accept = rx_valid && rx_ready;

        // Idle sockets age on a coarse tick; a zero timeout never closes
        tick = tick_cnt == 32'(TICK_CYCLES - 1);
        next_tick_cnt = tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
        for (int i = 0; i < tlf_pkg::NSOCK; i++) begin
            if (tab[i].open) begin
                if (tick && tab[i].idle != 16'hffff) begin
                    next_tab[i].idle = tab[i].idle + 16'h0001;
                end
                if (idle_tm != 16'h0000 && tab[i].idle >= idle_tm) begin
                    next_tab[i].open = 1'b0;
                end
            end
        end

        if (accept && !rx_last) begin
            next_csum = csum + rx_data;
            next_idx = (idx == tlf_pkg::IDX_MAX) ? idx : idx + 11'h001;
            if (idx == tlf_pkg::IDX_TYPE) begin
                next_ftype = rx_data;
            end else if (idx == tlf_pkg::IDX_FID) begin
                next_fid = rx_data;
            end else if (ftype == tlf_pkg::TYPE_TX_TLS) begin
                if (idx <= tlf_pkg::IDX_DADDR_LAST) begin
                    next_daddr = {daddr[23:0], rx_data};
                end else if (idx <= tlf_pkg::IDX_DPORT_LAST) begin
                    next_dport = {dport[7:0], rx_data};
                end else if (idx <= tlf_pkg::IDX_SPORT_LAST) begin
                    next_sport = {sport[7:0], rx_data};
                end else if (idx == tlf_pkg::IDX_PROFILE) begin
                    next_prof = rx_data;
                end else if (idx == tlf_pkg::IDX_OPTIONS) begin
                    next_opts = rx_data;
                    next_sock_ok = 1'b0;
                    next_tx_st = (sport == 16'h0000) ? tlf_pkg::TXST_RESOURCE
                                                     : tlf_pkg::TXST_NO_CONN;
                    for (int i = 0; i < tlf_pkg::NSOCK; i++) begin
                        if (!found && sock_match(tab[i], daddr, dport, sport)) begin
                            found = 1'b1;
                            next_sock_sel = 2'(i);
                        end
                    end
                    // No match on a zero source port opens a fresh socket
                    for (int i = 0; i < tlf_pkg::NSOCK; i++) begin
                        if (!found && sport == 16'h0000 && !tab[i].open) begin
                            found = 1'b1;
                            next_sock_sel = 2'(i);
                            next_tab[i].open = 1'b1;
                            next_tab[i].src_port = tlf_pkg::EPHEM_PORT_BASE + 16'(i);
                            next_tab[i].dst_addr = daddr;
                            next_tab[i].dst_port = dport;
                        end
                    end
                    if (found) begin
                        next_sock_ok = 1'b1;
                        next_tx_st = tlf_pkg::TXST_OK;
                        next_tab[next_sock_sel].idle = 16'h0000;
                        next_tab[next_sock_sel].profile = prof;
                    end
                end else if (sock_ok) begin
                    // One byte held back so the last one can carry the end mark
                    if (paylen == tlf_pkg::MAX_PAYLOAD) begin
                        next_too_long = 1'b1;
                        next_tx_st = tlf_pkg::TXST_TOO_LONG;
                    end else begin
                        push = pend_v;
                        push_word = '{drop: 1'b0, last: 1'b0, sock: sock_sel,
                                      profile: prof, data: pend_byte};
                        next_pend_byte = rx_data;
                        next_pend_v = 1'b1;
                        next_paylen = paylen + 11'h001;
                    end
                end
            end else if (ftype == tlf_pkg::TYPE_CFG_CMD) begin
                if (idx == tlf_pkg::IDX_CMD_HI) begin
                    next_cmd_hi = rx_data;
                end else if (idx == tlf_pkg::IDX_CMD_LO) begin
                    next_cmd_lo = rx_data;
                end else begin
                    next_par_hi = par_lo;
                    next_par_lo = rx_data;
                end
            end
        end

        if (accept && rx_last) begin
            good = (csum + rx_data) == tlf_pkg::CSUM_GOOD;
            next_idx = '0;
            next_csum = '0;
            next_paylen = '0;
            next_pend_v = 1'b0;
            next_too_long = 1'b0;
            next_sock_ok = 1'b0;
            if (ftype == tlf_pkg::TYPE_TX_TLS && idx > tlf_pkg::IDX_FID) begin
                // Bad checksum or overflow marks the last word for the consumer to drop
                push = pend_v && sock_ok;
                push_word = '{drop: !good || too_long, last: 1'b1, sock: sock_sel,
                              profile: prof, data: pend_byte};
                if (good && sock_ok && opts[tlf_pkg::OPT_CLOSE_BIT] && !tlf_pkg::TLS_IS_UDP) begin
                    next_tab[sock_sel].open = 1'b0;
                end
                next_rbuf[0] = tlf_pkg::TYPE_TX_STATUS;
                next_rbuf[1] = fid;
                next_rbuf[2] = (idx <= tlf_pkg::IDX_OPTIONS) ? tlf_pkg::TXST_BAD_FRAME :
                               (sock_ok && !pend_v) ? tlf_pkg::TXST_BAD_FRAME : tx_st;
                next_rlen = tlf_pkg::RESP_LEN_STATUS;
                resp_start = good && fid != 8'h00;
            end else if (ftype == tlf_pkg::TYPE_CFG_CMD && idx > tlf_pkg::IDX_FID) begin
                next_rlen = tlf_pkg::RESP_LEN_CFG_SET;
                if (idx <= tlf_pkg::IDX_CMD_LO) begin
                    cfg_st = tlf_pkg::CFG_ERROR;
                end else if (cmd_hi != tlf_pkg::CMD_IDLE_HI || cmd_lo != tlf_pkg::CMD_IDLE_LO) begin
                    cfg_st = tlf_pkg::CFG_BAD_CMD;
                end else if (idx == tlf_pkg::IDX_PARAM) begin
                    next_rlen = tlf_pkg::RESP_LEN_CFG_GET;
                end else if (idx == tlf_pkg::IDX_PARAM + 11'h002) begin
                    if (good) begin
                        next_idle_tm = {par_hi, par_lo};
                    end
                end else begin
                    cfg_st = tlf_pkg::CFG_BAD_PARAM;
                end
                next_rbuf[0] = tlf_pkg::TYPE_CFG_RESP;
                next_rbuf[1] = fid;
                next_rbuf[2] = cmd_hi;
                next_rbuf[3] = cmd_lo;
                next_rbuf[4] = cfg_st;
                next_rbuf[5] = idle_tm[15:8];
                next_rbuf[6] = idle_tm[7:0];
                resp_start = good && fid != 8'h00;
            end
        end

        // Push lands one cycle after ready is seen, so keep a slot spare
        next_rx_ready = ({1'b0, fifo_cnt} + 4'(push)) < 4'(tlf_pkg::FIFO_DEPTH) &&
                        !resp_start && ser_state == S_IDLE && !host_valid && fifo_ready;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            idx <= '0;
            paylen <= '0;
            ftype <= '0;
            fid <= '0;
            prof <= '0;
            opts <= '0;
            pend_byte <= '0;
            csum <= '0;
            tx_st <= '0;
            cmd_hi <= '0;
            cmd_lo <= '0;
            par_hi <= '0;
            par_lo <= '0;
            daddr <= '0;
            tick_cnt <= '0;
            dport <= '0;
            sport <= '0;
            idle_tm <= tlf_pkg::IDLE_TIMEOUT_RESET;
            pend_v <= 1'b0;
            sock_ok <= 1'b0;
            too_long <= 1'b0;
            sock_sel <= '0;
            tab <= '{default: '0};
            rbuf <= '{default: '0};
            rlen <= '0;
            rx_ready <= 1'b0;
        end else begin
            idx <= next_idx;
            paylen <= next_paylen;
            ftype <= next_ftype;
            fid <= next_fid;
            prof <= next_prof;
            opts <= next_opts;
            pend_byte <= next_pend_byte;
            csum <= next_csum;
            tx_st <= next_tx_st;
            cmd_hi <= next_cmd_hi;
            cmd_lo <= next_cmd_lo;
            par_hi <= next_par_hi;
            par_lo <= next_par_lo;
            daddr <= next_daddr;
            tick_cnt <= next_tick_cnt;
            dport <= next_dport;
            sport <= next_sport;
            idle_tm <= next_idle_tm;
            pend_v <= next_pend_v;
            sock_ok <= next_sock_ok;
            too_long <= next_too_long;
            sock_sel <= next_sock_sel;
            tab <= next_tab;
            rbuf <= next_rbuf;
            rlen <= next_rlen;
            rx_ready <= next_rx_ready;
        end
    end

    // Envelope serializer: delimiter, length, data, checksum
    always_comb begin
        next_ser_state = ser_state;
        next_ser_idx = ser_idx;
        next_ser_csum = ser_csum;
        next_host_valid = host_valid && !host_ready;
        next_host_data = host_data;
        if (!host_valid || host_ready) begin
            unique case (ser_state)
                S_IDLE: begin
                    if (resp_start) begin
                        next_host_valid = 1'b1;
                        next_host_data = tlf_pkg::FRAME_DELIM;
                        next_ser_state = S_LENH;
                    end
                end
                S_LENH: begin
                    next_host_valid = 1'b1;
                    next_host_data = 8'h00;
                    next_ser_state = S_LENL;
                end
                S_LENL: begin
                    next_host_valid = 1'b1;
                    next_host_data = {5'h00, rlen};
                    next_ser_idx = '0;
                    next_ser_csum = '0;
                    next_ser_state = S_DATA;
                end
                S_DATA: begin
                    next_host_valid = 1'b1;
                    next_host_data = rbuf[ser_idx];
                    next_ser_csum = ser_csum + rbuf[ser_idx];
                    next_ser_idx = ser_idx + 3'h1;
                    if (ser_idx == rlen - 3'h1) begin
                        next_ser_state = S_SUM;
                    end
                end
                S_SUM: begin
                    next_host_valid = 1'b1;
                    next_host_data = tlf_pkg::CSUM_GOOD - ser_csum;
                    next_ser_state = S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ser_state <= S_IDLE;
            ser_idx <= '0;
            ser_csum <= '0;
            host_valid <= 1'b0;
            host_data <= '0;
        end else begin
            ser_state <= next_ser_state;
            ser_idx <= next_ser_idx;
            ser_csum <= next_ser_csum;
            host_valid <= next_host_valid;
            host_data <= next_host_data;
        end
    end

    tlf_fifo #(
        .WIDTH($bits(tlf_pkg::tlf_net_word_t)),
        .DEPTH(tlf_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .in_valid(push),
        .in_data(push_word),
        .in_ready(fifo_ready),
        .out_valid(net_valid),
        .out_data(net_word),
        .out_ready(net_ready),
        .count(fifo_cnt)
    );
endmodule // tlf_framer
`default_nettype wire

// File: tb/tlf_chk_sva.sv
// Assertion checker for the secure transmit and config response framer
`timescale 1ns/10ps
`default_nettype none
module tlf_chk (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    input wire logic rx_ready,
    input wire logic host_valid,
    input wire logic [7:0] host_data,
    input wire logic host_ready,
    input wire logic net_valid,
    input wire tlf_pkg::tlf_net_word_t net_word,
    input wire logic net_ready
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    logic [10:0] idx;
    logic [7:0] len, typ, sum;
    wire logic tk = host_valid && host_ready;
    // Checksum byte ends the outgoing envelope
    wire logic at_end = idx > 11'h002 && idx == {3'h0, len} + 11'h003;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            idx <= 11'h000;
            len <= 8'h00;
            typ <= 8'h00;
            sum <= 8'h00;
        end else if (tk) begin
            idx <= at_end ? 11'h000 : idx + 11'h001;
            len <= idx == 11'h002 ? host_data : len;
            typ <= idx == 11'h003 ? host_data : typ;
            sum <= idx > 11'h002 ? sum + host_data : 8'h00;
        end
    end
    sequence frame_end;
        rx_valid && rx_ready && rx_last;
    endsequence
    sequence resp_open;
        $rose(host_valid) && host_data == tlf_pkg::FRAME_DELIM;
    endsequence
    chk_answer_edge: assert property (frame_end ##1 host_valid |-> resp_open)
        else $error("response not opened after frame end");
    chk_resp_cause: assert property ($rose(host_valid) |-> $past(rx_valid && rx_ready && rx_last))
        else $error("response without a finished frame");
    chk_host_hold: assert property (host_valid && !host_ready |=> host_valid && $stable(host_data))
        else $error("response byte dropped before taken");
    chk_net_hold: assert property (net_valid && !net_ready |=> net_valid && $stable(net_word))
        else $error("payload word dropped before taken");
    chk_len_high: assert property (tk && idx == 11'h001 |-> host_data == 8'h00)
        else $error("length high byte not zero");
    chk_frame_type: assert property (host_valid && idx == 11'h003 |-> host_data ==
        (len == 8'h03 ? tlf_pkg::TYPE_TX_STATUS : tlf_pkg::TYPE_CFG_RESP))
        else $error("response type does not fit length");
    chk_cfg_status: assert property (host_valid && idx == 11'h007 && typ ==
        tlf_pkg::TYPE_CFG_RESP |-> host_data <= tlf_pkg::CFG_BAD_PARAM)
        else $error("config status out of range");
    chk_csum_byte: assert property (host_valid && at_end |-> 8'(sum + host_data) == 8'hff)
        else $error("response checksum wrong");
    chk_rx_hold: assert property (host_valid |-> !rx_ready)
        else $error("request bytes taken during a response");
    chk_drop_last: assert property (net_valid && net_word.drop |-> net_word.last)
        else $error("drop mark away from last word");
endmodule // tlf_chk
`default_nettype wire

// File: tb/tlf_host_model.sv
// Host partner: sends request frames and collects response bytes
`timescale 1ns/10ps
`default_nettype none
module tlf_host_model (
    input wire logic clk_sys,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_last,
    input wire logic rx_ready,
    input wire logic host_valid,
    input wire logic [7:0] host_data,
    output logic host_ready,
    input wire logic slow
);
    logic [7:0] got[$];
    // Slow mode takes a byte only every other cycle
    always @(posedge clk_sys) begin
        if (host_valid && host_ready) got.push_back(host_data);
        host_ready <= slow ? !host_ready : 1'b1;
    end
    task automatic send(input logic [7:0] f[$], input logic bad);
        logic [7:0] s;
        int n;
        s = 8'h00;
        foreach (f[i]) s += f[i];
        f.push_back((8'hff - s) ^ {7'h00, bad});
        foreach (f[i]) begin
            rx_valid <= 1'b1;
            rx_data <= f[i];
            rx_last <= i == f.size() - 1;
            n = 0;
            do begin
                @(posedge clk_sys);
                n++;
            end while (!rx_ready && n < 2000);
        end
        rx_valid <= 1'b0;
        rx_last <= 1'b0;
        // Released data line must not keep showing the last byte
        rx_data <= ~f[f.size() - 1];
    endtask
endmodule // tlf_host_model
`default_nettype wire

// File: tb/tlf_framer_tb.sv
// Self-checking bench for the secure transmit and config response framer
`timescale 1ns/10ps
`default_nettype none
module tlf_framer_tb;
    typedef struct {
        logic [7:0] typ, id;
        logic [15:0] w, v;
        int n;
        logic [7:0] opt;
        logic bad;
        logic [7:0] st;
        int nexp;
    } tlf_row_t;
    logic clk_sys, rst_b, rx_valid, rx_last, rx_ready, host_valid, host_ready;
    logic net_valid, net_ready, slow;
    logic [7:0] rx_data, host_data;
    tlf_pkg::tlf_net_word_t net_word, w;
    tlf_pkg::tlf_net_word_t net_q[$];
    tlf_row_t rows[15];
    int mismatches, compares;
    tlf_framer #(.TICK_CYCLES(8)) dut (.clk_sys, .rst_b, .rx_valid, .rx_data, .rx_last,
        .rx_ready, .host_valid, .host_data, .host_ready, .net_valid, .net_word, .net_ready);
    tlf_host_model host (.clk_sys, .rx_valid, .rx_data, .rx_last, .rx_ready, .host_valid,
        .host_data, .host_ready, .slow);
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (net_valid && net_ready) net_q.push_back(net_word);
        net_ready <= slow ? !net_ready : 1'b1;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic run(input tlf_row_t r);
        logic [7:0] f[$];
        logic [7:0] e[$];
        logic [7:0] s;
        logic tx;
        int i, nn;
        tx = r.typ == tlf_pkg::TYPE_TX_TLS;
        nn = tx ? r.nexp : 0;
        if (tx) f = {r.typ, r.id, 8'h0a, 8'h00, 8'h00, 8'h01, 8'h00, 8'h50, r.w[15:8],
            r.w[7:0], r.id & 8'h03, r.opt};
        else f = {r.typ, r.id, r.w[15:8], r.w[7:0]};
        for (i = 0; i < r.n; i++)
            f.push_back(tx ? 8'hd0 + 8'(i) : r.v[8 * (r.n - i) - 1 -: 8]);
        e = {};
        if (r.id != 8'h00 && !r.bad) begin
            if (tx) e = {tlf_pkg::TYPE_TX_STATUS, r.id, r.st};
            else e = {tlf_pkg::TYPE_CFG_RESP, r.id, r.w[15:8], r.w[7:0], r.st};
            if (!tx && r.nexp == 2) e = {e, r.v[15:8], r.v[7:0]};
            s = 8'h00;
            foreach (e[j]) s += e[j];
            e = {tlf_pkg::FRAME_DELIM, 8'h00, 8'(e.size()), e, 8'hff - s};
        end
        host.got = {};
        net_q = {};
        host.send(f, r.bad);
        for (i = 0; i < 5000 && (host.got.size() < e.size() || net_q.size() < nn); i++)
            @(posedge clk_sys);
        if (i == 5000) begin
            mismatches++;
            final_report();
        end
        repeat (20) @(posedge clk_sys);
        check(host.got.size(), e.size());
        foreach (e[j]) check(host.got[j], e[j]);
        check(net_q.size(), nn);
        for (i = 0; i < nn; i++) begin
            w = '{drop: (r.bad || r.n > 1500) && i == nn - 1, last: i == nn - 1, sock: 2'h0,
                profile: r.id & 8'h03, data: 8'hd0 + 8'(i)};
            check(net_q[i], w);
        end
    endtask
    initial begin
        rows = '{'{8'h23, 8'h05, 16'h0000, 16'h0000, 2, 8'h00, 1'b0, 8'h00, 2},
            '{8'h23, 8'h00, 16'h0000, 16'h0000, 1, 8'h00, 1'b0, 8'h00, 1},
            '{8'h23, 8'h06, 16'h1234, 16'h0000, 1, 8'h00, 1'b0, 8'h20, 0},
            '{8'h23, 8'h07, 16'hc000, 16'h0000, 1, 8'h02, 1'b0, 8'h00, 1},
            '{8'h23, 8'h08, 16'hc000, 16'h0000, 1, 8'h00, 1'b0, 8'h20, 0},
            '{8'h23, 8'h09, 16'h0000, 16'h0000, 1, 8'h00, 1'b1, 8'h00, 1},
            '{8'h23, 8'h0a, 16'h0000, 16'h0000, 1501, 8'h00, 1'b0, 8'h74, 1500},
            '{8'h08, 8'h07, 16'h544d, 16'h012c, 0, 8'h00, 1'b0, 8'h00, 2},
            '{8'h08, 8'h0b, 16'h544d, 16'h0000, 2, 8'h00, 1'b0, 8'h00, 0},
            '{8'h08, 8'h0c, 16'h544d, 16'h0000, 0, 8'h00, 1'b0, 8'h00, 2},
            '{8'h08, 8'h0d, 16'h5858, 16'h0000, 0, 8'h00, 1'b0, 8'h02, 0},
            '{8'h08, 8'h0e, 16'h544d, 16'h0005, 1, 8'h00, 1'b0, 8'h03, 0},
            '{8'h08, 8'h00, 16'h544d, 16'h0007, 2, 8'h00, 1'b0, 8'h00, 0},
            '{8'h08, 8'h0f, 16'h544d, 16'h0007, 0, 8'h00, 1'b0, 8'h00, 2},
            '{8'h23, 8'h11, 16'hc000, 16'h0000, 1, 8'h00, 1'b0, 8'h20, 0}};
        mismatches = 0;
        compares = 0;
        slow = 1'b0;
        rst_b = 1'b0;
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        foreach (rows[k]) begin
            slow <= k[0];
            run(rows[k]);
        end
        // Reset lands while a response is pending
        host.send({8'h08, 8'h10, 8'h54, 8'h4d}, 1'b0);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        check({host_valid, net_valid, rx_ready, host_data, net_word}, 0);
        @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        #1;
        check(rx_ready, 1'b1);
        @(posedge clk_sys);
        run(rows[7]);
        final_report();
    end
endmodule // tlf_framer_tb
bind tlf_framer tlf_chk chk (.clk_sys, .rst_b, .rx_valid, .rx_data, .rx_last, .rx_ready,
    .host_valid, .host_data, .host_ready, .net_valid, .net_word, .net_ready);
`default_nettype wire
